// >>> rtl/cpu_registers_and_status_flags.sv
/*
  programmer-visible register set of the 8-bit core: accumulator, index
  registers, stack pointer and page, program counter, status flags, the
  stack push sequencer and the core mode register.
  assumes the caller fetches memory operands and offers a request only
  while READY is high; memory writes leave on MEM_WR for one cycle.
*/
`timescale 1ns/1ps
module cpu_registers_and_status_flags (
  input wire logic CLK_SYS, // core clock
  input wire logic SRST, // synchronous reset, high
  input wire cpu_regs_pkg::request_type REQ, // decoded operation
  input wire logic IRQ_REQ, // interrupt request level
  input wire logic [15:0] VECTOR, // service address of interrupt or break
  output logic READY, // request may be offered
  output logic [7:0] ACC, // accumulator
  output logic [7:0] IDX_X, // first index register
  output logic [7:0] IDX_Y, // second index register
  output logic [7:0] STACK_PTR, // stack pointer
  output logic [15:0] PC, // program counter
  output logic [7:0] STATUS, // live status flags
  output logic [7:0] CORE_MODE, // core mode register
  output logic [15:0] STACK_ADDR, // address of next push
  output logic [15:0] EFF_ADDR, // indexed operand address
  output cpu_regs_pkg::mem_write_type MEM_WR, // memory write strobe
  output logic IRQ_ACK, // interrupt accepted pulse
  output logic WAITING, // held by wait op
  output logic HALTED, // oscillator stopped
  output logic ILLEGAL_OP, // refused op pulse
  output logic FLAGS_VALID // zero, overflow, negative meaningful
);
  import cpu_regs_pkg::*;

  typedef struct packed {
    state_type state;
    logic [7:0] acc;
    logic [7:0] x;
    logic [7:0] y;
    logic [7:0] sp;
    logic [15:0] pc;
    logic [7:0] status;
    logic [7:0] mode;
    logic [15:0] eff_addr;
    mem_write_type mem_wr;
    logic [15:0] ret;
    logic [7:0] saved_ps;
    logic brk_mark;
    logic push_ps;
    logic ready;
    logic irq_ack;
    logic illegal;
    logic flags_valid;
    logic waiting;
    logic halted;
    logic [15:0] push_addr;
  } regs_type;

  localparam regs_type REGS_RESET = '{
    state: ST_IDLE, acc: 8'h00, x: 8'h00, y: 8'h00, sp: SP_RESET, pc: PC_RESET,
    status: STATUS_RESET, mode: CORE_MODE_RESET, eff_addr: 16'h0000,
    mem_wr: '0, ret: 16'h0000, saved_ps: 8'h00, brk_mark: 1'b0, push_ps: 1'b0,
    ready: 1'b1, irq_ack: 1'b0, illegal: 1'b0, flags_valid: 1'b1, waiting: 1'b0, halted: 1'b0,
    push_addr: {ZERO_PAGE, SP_RESET}};

  regs_type r;
  regs_type next_r;
  logic [9:0] alu_out;
  logic [7:0] op_a;
  logic [15:0] product;
  logic [15:0] quotient;
  logic [15:0] remainder;
  logic [15:0] ret_addr;
  logic irq_take;

  // stack page comes from the mode register bit, low byte from the pointer
  function automatic logic [15:0] stack_addr(input logic [7:0] mode, input logic [7:0] sp);
    stack_addr = {(mode[STACK_PAGE_BIT] ? ONE_PAGE : ZERO_PAGE), sp};
  endfunction

  // zero and negative from a result byte
  function automatic logic [7:0] set_zn(input logic [7:0] st, input logic [7:0] v);
    logic [7:0] s;
    s = st;
    s[FLAG_Z] = (v == 8'h00);
    s[FLAG_N] = v[7];
    set_zn = s;
  endfunction

  // add or subtract, binary or decimal; returns {carry, overflow, result}
  function automatic logic [9:0] alu(input logic [7:0] a, input logic [7:0] b,
                                     input logic cin, input logic sub, input logic dec);
    logic [7:0] bb;
    logic [8:0] s;
    logic [4:0] lo;
    logic [4:0] hi;
    logic v;
    bb = sub ? ~b : b;
    s = {1'b0, a} + {1'b0, bb} + {8'h00, cin};
    v = ~(a[7] ^ bb[7]) & (a[7] ^ s[7]);
    alu = {s[8], v, s[7:0]};
    if (dec && !sub) begin
      // nibble correction; flags other than carry are not trusted here
      lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      if (lo > BCD_LIMIT) begin
        lo = lo + BCD_ADJUST;
      end
      hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
      if (hi > BCD_LIMIT) begin
        hi = hi + BCD_ADJUST;
      end
      alu = {hi[4], v, hi[3:0], lo[3:0]};
    end else if (dec) begin
      lo = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ~cin};
      if (lo[4]) begin
        lo = lo - BCD_ADJUST;
      end
      hi = {1'b0, a[7:4]} - {1'b0, b[7:4]} - {4'h0, lo[4]};
      if (hi[4]) begin
        hi = hi - BCD_ADJUST;
      end
      alu = {~hi[4], v, hi[3:0], lo[3:0]};
    end
  endfunction

  // next-state logic for the whole register set
  always_comb begin
    next_r = r;
    next_r.mem_wr.we = 1'b0;
    next_r.irq_ack = 1'b0;
    next_r.illegal = 1'b0;
    irq_take = IRQ_REQ && !r.status[FLAG_I];
    op_a = r.status[FLAG_T] ? REQ.x_data : r.acc;
    alu_out = alu(op_a, REQ.data, r.status[FLAG_C], REQ.op == SUBTRACT_WITH_BORROW_OP,
                  r.status[FLAG_D]);
    product = {8'h00, r.acc} * {8'h00, REQ.data};
    quotient = 16'h0000;
    remainder = 16'h0000;
    if (REQ.data != 8'h00) begin
      quotient = {r.y, r.acc} / {8'h00, REQ.data};
      remainder = {r.y, r.acc} % {8'h00, REQ.data};
    end
    ret_addr = r.pc + {14'h0000, REQ.len};
    case (r.state)
      ST_IDLE: begin
        if (irq_take || (REQ.valid && (REQ.op == SOFTWARE_BREAK_OP || REQ.op == CALL_OP))) begin
          // entry: high return byte now, low byte follows, then status for interrupt and break only
          next_r.ret = irq_take ? r.pc : ret_addr;
          next_r.push_ps = irq_take || REQ.op == SOFTWARE_BREAK_OP;
          next_r.brk_mark = !irq_take;
          next_r.saved_ps = r.status;
          next_r.mem_wr = '{1'b1, stack_addr(r.mode, r.sp), next_r.ret[15:8]};
          next_r.sp = r.sp - 8'h01;
          next_r.state = ST_PUSH_LO;
          if (irq_take || REQ.op == SOFTWARE_BREAK_OP) begin
            next_r.pc = VECTOR;
            next_r.status[FLAG_I] = 1'b1;
            next_r.irq_ack = irq_take;
          end else begin
            next_r.pc = REQ.addr;
          end
        end else if (REQ.valid) begin
          next_r.pc = ret_addr;
          next_r.eff_addr = REQ.addr + {8'h00, REQ.use_y ? r.y : r.x};
          case (REQ.op)
            ADD_WITH_CARRY_OP, SUBTRACT_WITH_BORROW_OP: begin
              next_r.status[FLAG_C] = alu_out[9];
              next_r.status[FLAG_V] = alu_out[8];
              next_r.status = set_zn(next_r.status, alu_out[7:0]);
              next_r.flags_valid = !r.status[FLAG_D];
              if (r.status[FLAG_T]) begin
                next_r.mem_wr = '{1'b1, {ZERO_PAGE, r.x}, alu_out[7:0]};
              end else begin
                next_r.acc = alu_out[7:0];
              end
            end
            LOAD_ACC_OP, POP_ACCUMULATOR_OP: begin
              next_r.acc = REQ.data;
              next_r.status = set_zn(r.status, REQ.data);
              next_r.flags_valid = 1'b1;
              if (REQ.op == POP_ACCUMULATOR_OP) begin
                next_r.sp = r.sp + 8'h01;
              end
            end
            LOAD_X_OP: begin
              next_r.x = REQ.data;
              next_r.status = set_zn(r.status, REQ.data);
              next_r.flags_valid = 1'b1;
            end
            LOAD_Y_OP: begin
              next_r.y = REQ.data;
              next_r.status = set_zn(r.status, REQ.data);
              next_r.flags_valid = 1'b1;
            end
            STORE_ACC_OP: begin
              // the mode register sits in the zero page, not in external memory
              if (REQ.addr == CORE_MODE_ADDR) begin
                next_r.mode = r.acc;
              end else begin
                next_r.mem_wr = '{1'b1, REQ.addr, r.acc};
              end
            end
            BIT_TEST_OP: begin
              next_r.status[FLAG_V] = REQ.data[6];
              next_r.status[FLAG_N] = REQ.data[7];
              next_r.status[FLAG_Z] = ((r.acc & REQ.data) == 8'h00);
              next_r.flags_valid = 1'b1;
            end
            SHIFT_LEFT_OP, ROTATE_LEFT_OP: begin
              next_r.acc = {r.acc[6:0], (REQ.op == ROTATE_LEFT_OP) & r.status[FLAG_C]};
              next_r.status[FLAG_C] = r.acc[7];
              next_r.status = set_zn(next_r.status, next_r.acc);
              next_r.flags_valid = 1'b1;
            end
            JUMP_OP: next_r.pc = REQ.addr;
            X_TO_STACK_OP: next_r.sp = r.x;
            CARRY_RAISE_OP: next_r.status[FLAG_C] = 1'b1;
            CARRY_LOWER_OP: next_r.status[FLAG_C] = 1'b0;
            IRQ_MASK_RAISE_OP: next_r.status[FLAG_I] = 1'b1;
            IRQ_MASK_LOWER_OP: next_r.status[FLAG_I] = 1'b0;
            DECIMAL_RAISE_OP: next_r.status[FLAG_D] = 1'b1;
            DECIMAL_LOWER_OP: next_r.status[FLAG_D] = 1'b0;
            INDEX_MODE_RAISE_OP: next_r.status[FLAG_T] = 1'b1;
            INDEX_MODE_LOWER_OP: next_r.status[FLAG_T] = 1'b0;
            OVERFLOW_LOWER_OP: next_r.status[FLAG_V] = 1'b0;
            PUSH_ACCUMULATOR_OP: begin
              next_r.mem_wr = '{1'b1, stack_addr(r.mode, r.sp), r.acc};
              next_r.sp = r.sp - 8'h01;
            end
            PUSH_STATUS_OP: begin
              next_r.mem_wr = '{1'b1, stack_addr(r.mode, r.sp), r.status};
              next_r.sp = r.sp - 8'h01;
            end
            POP_STATUS_OP: begin
              next_r.status = REQ.data;
              next_r.status[FLAG_B] = 1'b0;
              next_r.sp = r.sp + 8'h01;
            end
            PRODUCT_OP: begin
              next_r.acc = product[7:0];
              next_r.y = product[15:8];
            end
            DIVIDE_OP: begin
              // divide by zero leaves both registers untouched
              if (REQ.data != 8'h00) begin
                next_r.acc = quotient[7:0];
                next_r.y = remainder[7:0];
              end
            end
            WAIT_OP: next_r.state = ST_WAIT;
            OSCILLATOR_HALT_OP: next_r.state = ST_HALT;
            UNSUPPORTED_OP_ONE, UNSUPPORTED_OP_TWO: begin
              next_r.pc = r.pc;
              next_r.illegal = 1'b1;
            end
            default: next_r.pc = ret_addr;
          endcase
        end
      end
      ST_PUSH_LO: begin
        next_r.mem_wr = '{1'b1, stack_addr(r.mode, r.sp), r.ret[7:0]};
        next_r.sp = r.sp - 8'h01;
        next_r.state = r.push_ps ? ST_PUSH_PS : ST_IDLE;
      end
      ST_PUSH_PS: begin
        // break is marked only in the pushed copy, never in the live flags
        next_r.mem_wr = '{1'b1, stack_addr(r.mode, r.sp),
                          r.saved_ps | ({7'h00, r.brk_mark} << FLAG_B)};
        next_r.sp = r.sp - 8'h01;
        next_r.state = ST_IDLE;
      end
      ST_WAIT, ST_HALT: begin
        // any request level wakes; a masked one just resumes execution
        if (IRQ_REQ) begin
          next_r.state = ST_IDLE;
        end
      end
      default: next_r.state = ST_IDLE;
    endcase
    next_r.ready = (next_r.state == ST_IDLE);
    next_r.waiting = (next_r.state == ST_WAIT);
    next_r.halted = (next_r.state == ST_HALT);
    next_r.push_addr = stack_addr(next_r.mode, next_r.sp);
    if (SRST) begin
      next_r = REGS_RESET;
    end
  end

  // register stage only
  always_ff @(posedge CLK_SYS) begin
    r <= next_r;
  end

  // outputs straight from the register stage
  assign READY = r.ready;
  assign ACC = r.acc;
  assign IDX_X = r.x;
  assign IDX_Y = r.y;
  assign STACK_PTR = r.sp;
  assign PC = r.pc;
  assign STATUS = r.status;
  assign CORE_MODE = r.mode;
  assign EFF_ADDR = r.eff_addr;
  assign MEM_WR = r.mem_wr;
  assign IRQ_ACK = r.irq_ack;
  assign ILLEGAL_OP = r.illegal;
  assign FLAGS_VALID = r.flags_valid;
  assign WAITING = r.waiting;
  assign HALTED = r.halted;
  assign STACK_ADDR = r.push_addr;
endmodule

// >>> rtl/cpu_regs_pkg.sv
/*
  constants, types and reset image for the core register set block.
  assumes one clock, synchronous reset, and a sequencer outside that
  decodes instructions and feeds one request per accepted cycle.
*/
package cpu_regs_pkg;
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_I = 2;
  localparam int FLAG_D = 3;
  localparam int FLAG_B = 4;
  localparam int FLAG_T = 5;
  localparam int FLAG_V = 6;
  localparam int FLAG_N = 7;
  localparam int STACK_PAGE_BIT = 2;
  localparam logic [7:0] STATUS_RESET = 8'h04;
  localparam logic [7:0] ZERO_PAGE = 8'h00;
  localparam logic [7:0] ONE_PAGE = 8'h01;
  localparam logic [15:0] CORE_MODE_ADDR = 16'h003B;
  localparam logic [7:0] CORE_MODE_RESET = 8'h00;
  localparam logic [7:0] SP_RESET = 8'hFF;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [4:0] BCD_LIMIT = 5'h09;
  localparam logic [4:0] BCD_ADJUST = 5'h06;

  typedef enum logic [5:0] {
    NOP_OP = 6'h00, LOAD_ACC_OP = 6'h01, LOAD_X_OP = 6'h02, LOAD_Y_OP = 6'h03,
    STORE_ACC_OP = 6'h04, ADD_WITH_CARRY_OP = 6'h05, SUBTRACT_WITH_BORROW_OP = 6'h06,
    BIT_TEST_OP = 6'h07, SHIFT_LEFT_OP = 6'h08, ROTATE_LEFT_OP = 6'h09,
    JUMP_OP = 6'h0A, CALL_OP = 6'h0B, X_TO_STACK_OP = 6'h0C,
    CARRY_RAISE_OP = 6'h10, CARRY_LOWER_OP = 6'h11, IRQ_MASK_RAISE_OP = 6'h12,
    IRQ_MASK_LOWER_OP = 6'h13, DECIMAL_RAISE_OP = 6'h14, DECIMAL_LOWER_OP = 6'h15,
    INDEX_MODE_RAISE_OP = 6'h16, INDEX_MODE_LOWER_OP = 6'h17, OVERFLOW_LOWER_OP = 6'h18,
    PUSH_ACCUMULATOR_OP = 6'h20, POP_ACCUMULATOR_OP = 6'h21, PUSH_STATUS_OP = 6'h22,
    POP_STATUS_OP = 6'h23, PRODUCT_OP = 6'h24, DIVIDE_OP = 6'h25, WAIT_OP = 6'h26,
    OSCILLATOR_HALT_OP = 6'h27, SOFTWARE_BREAK_OP = 6'h28,
    UNSUPPORTED_OP_ONE = 6'h30, UNSUPPORTED_OP_TWO = 6'h31
  } op_type;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001, ST_PUSH_LO = 5'b00010, ST_PUSH_PS = 5'b00100,
    ST_WAIT = 5'b01000, ST_HALT = 5'b10000
  } state_type;

  typedef struct packed {
    logic valid;
    op_type op;
    logic [7:0] data;
    logic [7:0] x_data;
    logic [15:0] addr;
    logic [1:0] len;
    logic use_y;
  } request_type;

  typedef struct packed {
    logic we;
    logic [15:0] addr;
    logic [7:0] data;
  } mem_write_type;
endpackage

// >>> sim/cpu_regs_properties.sv
/*
  checker for the core register set: flags, stack address, entry pushes
  and refused ops, seen from the top module's ports only.
  assumes the single clock domain and the synchronous reset of the block.
*/
`timescale 1ns/1ps
module cpu_regs_properties
  import cpu_regs_pkg::*;
(
  input logic CLK_SYS, // core clock
  input logic SRST, // synchronous reset
  input cpu_regs_pkg::request_type REQ, // decoded operation
  input logic IRQ_REQ, // interrupt request
  input logic [15:0] VECTOR, // service address
  input logic READY, // request may be offered
  input logic [7:0] ACC, // accumulator
  input logic [7:0] IDX_X, // first index
  input logic [7:0] IDX_Y, // second index
  input logic [7:0] STACK_PTR, // stack pointer
  input logic [15:0] PC, // program counter
  input logic [7:0] STATUS, // live flags
  input logic [7:0] CORE_MODE, // core mode register
  input logic [15:0] STACK_ADDR, // next push address
  input logic [15:0] EFF_ADDR, // indexed address
  input cpu_regs_pkg::mem_write_type MEM_WR, // write strobe
  input logic IRQ_ACK, // interrupt accepted
  input logic WAITING, // wait state
  input logic HALTED, // halt state
  input logic ILLEGAL_OP, // refused op
  input logic FLAGS_VALID // flags meaningful
);
  // a request counts only when no interrupt wins the same edge
  logic taken;
  assign taken = READY && REQ.valid && !(IRQ_REQ && !STATUS[FLAG_I]);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SRST);
  property p_break_low; STATUS[FLAG_B] == 1'b0; endproperty
  a_break_low: assert property (p_break_low) else $error("live break flag set");
  property p_stack_follow;
    STACK_ADDR == {7'h00, CORE_MODE[STACK_PAGE_BIT], STACK_PTR};
  endproperty
  a_stack_follow: assert property (p_stack_follow) else $error("stack address off");
  property p_irq_entry;
    IRQ_REQ && !STATUS[FLAG_I] && READY |=> IRQ_ACK && STATUS[FLAG_I] && !READY
      && PC == $past(VECTOR);
  endproperty
  a_irq_entry: assert property (p_irq_entry) else $error("interrupt entry wrong");
  property p_mask_blocks; STATUS[FLAG_I] |=> !IRQ_ACK; endproperty
  a_mask_blocks: assert property (p_mask_blocks) else $error("masked irq taken");
  property p_irq_seq;
    IRQ_ACK |-> MEM_WR.we && MEM_WR.data == $past(PC[15:8]) ##1 MEM_WR.we
      ##1 (MEM_WR.we && !MEM_WR.data[FLAG_B] && READY);
  endproperty
  a_irq_seq: assert property (p_irq_seq) else $error("interrupt pushes wrong");
  property p_brk_seq;
    taken && REQ.op == SOFTWARE_BREAK_OP |=> MEM_WR.we && PC == $past(VECTOR)
      ##1 MEM_WR.we ##1 (MEM_WR.we && MEM_WR.data[FLAG_B]);
  endproperty
  a_brk_seq: assert property (p_brk_seq) else $error("break pushes wrong");
  property p_illegal;
    taken && (REQ.op == UNSUPPORTED_OP_ONE || REQ.op == UNSUPPORTED_OP_TWO)
      |=> ILLEGAL_OP && $stable(PC);
  endproperty
  a_illegal: assert property (p_illegal) else $error("unsupported op not refused");
  property p_decimal_valid;
    taken && (REQ.op == ADD_WITH_CARRY_OP || REQ.op == SUBTRACT_WITH_BORROW_OP)
      |=> FLAGS_VALID != $past(STATUS[FLAG_D]);
  endproperty
  a_decimal_valid: assert property (p_decimal_valid) else $error("flag validity wrong");
  property p_load_flags;
    taken && REQ.op == LOAD_ACC_OP |=> ACC == $past(REQ.data)
      && STATUS[FLAG_Z] == (ACC == 8'h00) && STATUS[FLAG_N] == ACC[7];
  endproperty
  a_load_flags: assert property (p_load_flags) else $error("load flags wrong");
  property p_load_addr;
    taken && REQ.op == LOAD_ACC_OP |=> PC == $past(PC) + $past(REQ.len)
      && EFF_ADDR == $past(REQ.addr) + $past(REQ.use_y ? IDX_Y : IDX_X);
  endproperty
  a_load_addr: assert property (p_load_addr) else $error("pc or address wrong");
  property p_bit_test;
    taken && REQ.op == BIT_TEST_OP |=> STATUS[FLAG_V] == $past(REQ.data[6])
      && STATUS[FLAG_N] == $past(REQ.data[7]);
  endproperty
  a_bit_test: assert property (p_bit_test) else $error("bit test flags wrong");
  c_irq: cover property (IRQ_ACK);
  c_illegal: cover property (ILLEGAL_OP);
  c_brk: cover property (taken && REQ.op == SOFTWARE_BREAK_OP);
  c_call: cover property (taken && REQ.op == CALL_OP);
endmodule
bind cpu_registers_and_status_flags cpu_regs_properties u_props (.CLK_SYS, .SRST, .REQ,
  .IRQ_REQ, .VECTOR, .READY, .ACC, .IDX_X, .IDX_Y, .STACK_PTR, .PC, .STATUS, .CORE_MODE,
  .STACK_ADDR, .EFF_ADDR, .MEM_WR, .IRQ_ACK, .WAITING, .HALTED, .ILLEGAL_OP, .FLAGS_VALID);

// >>> sim/test_cpu_registers_and_status_flags.sv
/*
  directed testbench for the core register set block.
  assumes the block alone, driven at its ports at the rising edge.
*/
`timescale 1ns/1ps
module test_cpu_registers_and_status_flags;
  import cpu_regs_pkg::*;
  logic clk_sys = 1'b0, srst = 1'b1, irq_req = 1'b0, ready, waiting, halted;
  logic irq_ack, illegal, flags_valid;
  logic [15:0] vector = 16'hC000, pc, stack_addr, eff_addr;
  logic [7:0] acc, idx_x, idx_y, sp, status, mode;
  request_type req = '0;
  mem_write_type mem_wr;
  int n_errors = 0, cmp_count = 0;
  // 200 MHz core clock
  always #2.5 clk_sys = ~clk_sys;
  cpu_registers_and_status_flags uut (.CLK_SYS(clk_sys), .SRST(srst), .REQ(req),
    .IRQ_REQ(irq_req), .VECTOR(vector), .READY(ready), .ACC(acc), .IDX_X(idx_x),
    .IDX_Y(idx_y), .STACK_PTR(sp), .PC(pc), .STATUS(status), .CORE_MODE(mode),
    .STACK_ADDR(stack_addr), .EFF_ADDR(eff_addr), .MEM_WR(mem_wr), .IRQ_ACK(irq_ack),
    .WAITING(waiting), .HALTED(halted), .ILLEGAL_OP(illegal), .FLAGS_VALID(flags_valid));
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // request held until an edge that samples ready high
  task automatic issue(input op_type op, input logic [7:0] d, input logic [15:0] a,
                       input logic y = 1'b0);
    int n;
    n = 0;
    req <= '{1'b1, op, d, 8'h03, a, 2'h1, y};
    do begin
      @(posedge clk_sys);
      n++;
    end while (ready !== 1'b1 && n < 40);
    if (n >= 40) begin
      n_errors++;
      test_done();
    end
  endtask
  task automatic run(input op_type op, input logic [7:0] d, input logic [15:0] a,
                     input logic y = 1'b0);
    @(posedge clk_sys);
    issue(op, d, a, y);
    req.valid <= 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic do_reset;
    @(posedge clk_sys);
    srst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    srst <= 1'b0;
    @(negedge clk_sys);
    chk(status, 8'h04, "status after reset");
    chk({pc, stack_addr}, 32'h000000FF, "pc and stack after reset");
  endtask
  task automatic t_load;
    run(LOAD_ACC_OP, 8'h00, 16'h1000);
    chk({pc, eff_addr}, {16'h0001, 16'h1000}, "zero load address");
    chk(status[FLAG_Z], 1'b1, "zero load");
    run(LOAD_ACC_OP, 8'h80, 16'h0000);
    chk({status[FLAG_N], status[FLAG_Z], acc}, {2'b10, 8'h80}, "negative load");
  endtask
  task automatic t_flags;
    op_type ops[9] = '{CARRY_RAISE_OP, CARRY_LOWER_OP, IRQ_MASK_RAISE_OP, IRQ_MASK_LOWER_OP,
      DECIMAL_RAISE_OP, DECIMAL_LOWER_OP, INDEX_MODE_RAISE_OP, INDEX_MODE_LOWER_OP,
      OVERFLOW_LOWER_OP};
    int bits[9] = '{FLAG_C, FLAG_C, FLAG_I, FLAG_I, FLAG_D, FLAG_D, FLAG_T, FLAG_T, FLAG_V};
    for (int i = 0; i < 9; i++) begin
      run(ops[i], 8'h00, 16'h0000);
      chk(status[bits[i]], 1'(i % 2 == 0 && i < 8), "flag op");
    end
  endtask
  // back-to-back adds, then decimal, then binary subtract
  task automatic t_arith;
    run(LOAD_ACC_OP, 8'h7F, 16'h0000);
    @(posedge clk_sys);
    issue(ADD_WITH_CARRY_OP, 8'h01, 16'h0000);
    issue(ADD_WITH_CARRY_OP, 8'h80, 16'h0000);
    req.valid <= 1'b0;
    @(negedge clk_sys);
    chk({status, acc}, 16'h4300, "binary add");
    run(DECIMAL_RAISE_OP, 8'h00, 16'h0000);
    run(CARRY_LOWER_OP, 8'h00, 16'h0000);
    run(LOAD_ACC_OP, 8'h19, 16'h0000);
    run(ADD_WITH_CARRY_OP, 8'h28, 16'h0000);
    chk({flags_valid, acc}, 9'h047, "decimal add");
    run(DECIMAL_LOWER_OP, 8'h00, 16'h0000);
    run(CARRY_RAISE_OP, 8'h00, 16'h0000);
    run(SUBTRACT_WITH_BORROW_OP, 8'h48, 16'h0000);
    chk({status[FLAG_C], status[FLAG_N], flags_valid, acc}, 11'h3FF, "subtract");
  endtask
  task automatic t_index;
    run(LOAD_X_OP, 8'h10, 16'h0000);
    run(INDEX_MODE_RAISE_OP, 8'h00, 16'h0000);
    run(CARRY_LOWER_OP, 8'h00, 16'h0000);
    run(ADD_WITH_CARRY_OP, 8'h05, 16'h0040);
    chk(mem_wr, {1'b1, 16'h0010, 8'h08}, "memory result");
    chk({acc, eff_addr}, 24'hFF0050, "acc kept, address");
    run(INDEX_MODE_LOWER_OP, 8'h00, 16'h0000);
    run(LOAD_ACC_OP, 8'h00, 16'h0000);
    run(BIT_TEST_OP, 8'hC0, 16'h0000);
    chk({status[FLAG_N], status[FLAG_V], status[FLAG_Z]}, 3'b111, "bit test");
  endtask
  task automatic t_stack;
    run(LOAD_ACC_OP, 8'h04, 16'h0000);
    run(STORE_ACC_OP, 8'h00, 16'h003B);
    chk({mode, mem_wr.we}, 9'h008, "mode write");
    run(PUSH_ACCUMULATOR_OP, 8'h00, 16'h0000);
    chk(mem_wr, {1'b1, 16'h01FF, 8'h04}, "push acc");
    chk(sp, 8'hFE, "push acc pointer");
    run(PUSH_STATUS_OP, 8'h00, 16'h0000);
    chk({mem_wr.addr, mem_wr.data[FLAG_B]}, 17'h003FC, "push status");
    run(POP_ACCUMULATOR_OP, 8'h5A, 16'h0000);
    chk({acc, sp}, 16'h5AFE, "pop acc");
    run(LOAD_ACC_OP, 8'h00, 16'h0000);
    run(STORE_ACC_OP, 8'h00, 16'h003B);
  endtask
  // second index, shift, rotate, decimal subtract, stack load, call, jump, status pop
  task automatic t_more;
    logic [15:0] p;
    run(LOAD_Y_OP, 8'h07, 16'h0000);
    run(LOAD_ACC_OP, 8'h81, 16'h0100, 1'b1);
    chk({idx_y, eff_addr}, 24'h070107, "second index");
    run(SHIFT_LEFT_OP, 8'h00, 16'h0000);
    chk({status[FLAG_C], acc}, 9'h102, "shift");
    run(ROTATE_LEFT_OP, 8'h00, 16'h0000);
    chk({status[FLAG_C], acc}, 9'h005, "rotate");
    run(DECIMAL_RAISE_OP, 8'h00, 16'h0000);
    run(CARRY_RAISE_OP, 8'h00, 16'h0000);
    run(LOAD_ACC_OP, 8'h47, 16'h0000);
    run(SUBTRACT_WITH_BORROW_OP, 8'h19, 16'h0000);
    chk({status[FLAG_C], flags_valid, acc}, 10'h228, "decimal subtract");
    run(DECIMAL_LOWER_OP, 8'h00, 16'h0000);
    run(LOAD_X_OP, 8'h80, 16'h0000);
    run(X_TO_STACK_OP, 8'h00, 16'h0000);
    chk({idx_x, sp}, 16'h8080, "stack load");
    p = pc + 16'h0001;
    run(CALL_OP, 8'h00, 16'h2345);
    chk({mem_wr.we, mem_wr.data, pc, ready}, {1'b1, p[15:8], 16'h2345, 1'b0}, "call");
    @(negedge clk_sys);
    chk({mem_wr.we, mem_wr.data, ready}, {1'b1, p[7:0], 1'b1}, "call low byte");
    run(JUMP_OP, 8'h00, 16'h1234);
    chk(pc, 16'h1234, "jump");
    run(POP_STATUS_OP, 8'hFF, 16'h0000);
    chk(status, 8'hEF, "status pop");
    run(POP_STATUS_OP, 8'h10, 16'h0000);
    chk(status, 8'h00, "status pop clear");
  endtask
  task automatic t_irq;
    logic [15:0] ret;
    int n;
    ret = pc;
    n = 0;
    @(posedge clk_sys);
    irq_req <= 1'b1;
    @(posedge clk_sys);
    irq_req <= 1'b0;
    @(negedge clk_sys);
    chk({irq_ack, status[FLAG_I], pc, mem_wr.data}, {2'b11, vector, ret[15:8]}, "entry");
    @(negedge clk_sys);
    chk(mem_wr.data, ret[7:0], "low return byte");
    @(negedge clk_sys);
    chk({mem_wr.we, mem_wr.data[FLAG_B]}, 2'b10, "irq status push");
    @(posedge clk_sys);
    irq_req <= 1'b1;
    repeat (6) begin
      @(negedge clk_sys);
      if (irq_ack === 1'b1) n++;
    end
    @(posedge clk_sys);
    irq_req <= 1'b0;
    chk(n, 0, "masked irq");
    run(SOFTWARE_BREAK_OP, 8'h00, 16'h0000);
    chk({mem_wr.we, pc}, {1'b1, vector}, "break entry");
    repeat (2) @(negedge clk_sys);
    chk({mem_wr.we, mem_wr.data[FLAG_B]}, 2'b11, "break status push");
  endtask
  task automatic t_ops;
    logic [15:0] p;
    op_type bad[2] = '{UNSUPPORTED_OP_ONE, UNSUPPORTED_OP_TWO};
    op_type low[2] = '{WAIT_OP, OSCILLATOR_HALT_OP};
    for (int i = 0; i < 2; i++) begin
      p = pc;
      run(bad[i], 8'h00, 16'h0000);
      chk({illegal, pc}, {1'b1, p}, "refused op");
    end
    run(LOAD_ACC_OP, 8'h05, 16'h0000);
    run(PRODUCT_OP, 8'h03, 16'h0000);
    chk({idx_y, acc}, 16'h000F, "product");
    run(DIVIDE_OP, 8'h04, 16'h0000);
    chk({idx_y, acc, illegal}, 17'h00606, "divide");
    for (int i = 0; i < 2; i++) begin
      // halt only issued on the main clock; this bench has no ring oscillator
      run(low[i], 8'h00, 16'h0000);
      chk({waiting, halted, ready}, {i == 0, i == 1, 1'b0}, "sleep state");
      @(posedge clk_sys);
      irq_req <= 1'b1;
      @(posedge clk_sys);
      irq_req <= 1'b0;
      @(negedge clk_sys);
      chk({waiting, halted}, 2'b00, "wake");
    end
  endtask
  initial begin
    do_reset();
    t_load();
    t_flags();
    t_arith();
    t_index();
    t_stack();
    t_more();
    t_irq();
    t_ops();
    do_reset();
    test_done();
  end
endmodule
